/* pkg/can_xfer_defines.svh */
/*
 * register offsets, field positions, reset values and timing counts of the
 * interface transfer-select block.
 * assumes an apb slave with byte addresses on paddr[7:0].
 */
`ifndef CAN_XFER_DEFINES_SVH
`define CAN_XFER_DEFINES_SVH

// ****************************************
// register byte offsets
// ****************************************
`define OFS_COMMAND_REQUEST  8'h20
`define OFS_COMMAND_MASK     8'h24
`define OFS_MESSAGE_CONTROL  8'h38
`define OFS_DATA_LOW_A       8'h3c
`define OFS_DATA_LOW_B       8'h40
`define OFS_DATA_HIGH_A      8'h44
`define OFS_DATA_HIGH_B      8'h48

// ****************************************
// field positions
// ****************************************
`define BIT_BUSY             15
`define BIT_DIRECTION        7
`define BIT_CLEAR_PENDING    3
`define BIT_NEW_DATA_TX      2
`define BIT_LOW_BYTES        1
`define BIT_HIGH_BYTES       0
`define BIT_MCTL_NEW_DATA    15
`define BIT_MCTL_PENDING     13
`define BIT_MCTL_TX_REQUEST  8

// ****************************************
// reset values and timing
// ****************************************
`define RST_OBJECT_NUMBER    6'h01
`define RST_COMMAND_MASK     8'h00
`define XFER_CYCLES          2'h3

`endif

/* pkg/can_xfer_pkg.sv */
/*
 * types shared by the transfer-select block.
 * assumes can_xfer_defines.svh supplies the numbers.
 */
package can_xfer_pkg;

   typedef enum logic {ST_IDLE, ST_BUSY} xfer_state_t;

   typedef struct packed
   {
      logic        pending;
      logic        new_data;
      logic        tx_request;
      logic [63:0] data;
   } msg_obj_t;

endpackage

/* hw/can_if_transfer_select.sv */
/*
 * interface register set and 32-object message store of a can controller,
 * moving flags and data bytes between them as the command mask selects.
 * assumes an apb master on pclk and a protocol engine that stores received
 * frames through rx_* and acknowledges transmissions through tx_done_*.
 */
// Our own choices: the APB register port and the register addresses.
`include "can_xfer_defines.svh"

// What this block does
// - write direction: clear pending if select set
// - read, no clear: copy pending to control
// - read with clear: clear pending, report old
// - write with new-data select starts transmission
// - read, no clear: copy new-data to control
// - read with clear: clear new-data, report old
// - low select moves data bytes 0-3
// - high select moves data bytes 4-7
// - object number write starts, sets busy
// - transfer completes after exactly 3 clocks
module can_if_transfer_select
   import can_xfer_pkg::*;
(
   // apb slave
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output      logic [31:0] prdata,
   output      logic        pready,
   output      logic        pslverr,
   // frames stored by the protocol engine
   input  wire logic        rx_store,
   input  wire logic [4:0]  rx_index,
   input  wire logic [63:0] rx_data,
   // transmission requests
   output      logic        tx_start,
   output      logic [4:0]  tx_index,
   input  wire logic        tx_done,
   input  wire logic [4:0]  tx_done_index
);

   // ****************************************
   // registers
   // ****************************************
   logic [5:0]   object_number_field;
   logic         busy;
   logic [1:0]   cnt;
   xfer_state_t  state;
   logic         cmsk_dir, clear_pending_select, cmsk_ndtx, low_bytes_select, high_bytes_select;
   logic         object_pending_flag, new_data_flag, transmit_request_flag;
   logic [15:0]  data_low_word_a, data_low_word_b, data_high_word_a, data_high_word_b;
   logic [4:0]   xfer_idx;
   msg_obj_t     objs [32];
   logic [31:0]  next_prdata;
   logic         mapped;

   wire logic wr_access = psel && penable && pwrite;
   wire logic crq_write = wr_access && paddr == `OFS_COMMAND_REQUEST;
   wire logic xfer_done = state == ST_BUSY && cnt == `XFER_CYCLES;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // ****************************************
   // register read mux
   // ****************************************
   always_comb
   begin
      next_prdata = 32'h0000_0000;
      mapped = 1'b1;
      unique case (paddr)
         `OFS_COMMAND_REQUEST: next_prdata = {16'h0000, busy, 9'h000, object_number_field};
         `OFS_COMMAND_MASK:    next_prdata = {24'h00_0000, cmsk_dir, 3'h0, clear_pending_select, cmsk_ndtx,
                                              low_bytes_select, high_bytes_select};
         `OFS_MESSAGE_CONTROL: next_prdata = {16'h0000, new_data_flag, 1'b0, object_pending_flag, 4'h0,
                                              transmit_request_flag, 8'h00};
         `OFS_DATA_LOW_A:      next_prdata = {16'h0000, data_low_word_a};
         `OFS_DATA_LOW_B:      next_prdata = {16'h0000, data_low_word_b};
         `OFS_DATA_HIGH_A:     next_prdata = {16'h0000, data_high_word_a};
         `OFS_DATA_HIGH_B:     next_prdata = {16'h0000, data_high_word_b};
         default:              mapped = 1'b0;
      endcase
   end

   // read data is latched in the setup cycle, stable through the access
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
         prdata <= next_prdata;
   end

   // ****************************************
   // command request, command mask and transfer sequencing
   // ****************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         object_number_field <= `RST_OBJECT_NUMBER;
         state <= ST_IDLE;
         busy <= 1'b0;
         cnt <= 2'h0;
         xfer_idx <= 5'h00;
      end
      else
      begin
         unique case (state)
            ST_IDLE:
               if (crq_write)
               begin
                  // number 0 and numbers above 32 wrap onto objects 32 and 1..31
                  object_number_field <= pwdata[5:0];
                  xfer_idx <= pwdata[4:0] - 5'h01;
                  state <= ST_BUSY;
                  busy <= 1'b1;
                  cnt <= 2'h1;
               end
            ST_BUSY:
               if (xfer_done)
               begin
                  state <= ST_IDLE;
                  busy <= 1'b0;
               end
               else
                  cnt <= cnt + 2'h1;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         {cmsk_dir, clear_pending_select, cmsk_ndtx, low_bytes_select, high_bytes_select} <= 5'h00;
      else if (wr_access && paddr == `OFS_COMMAND_MASK)
      begin
         cmsk_dir <= pwdata[`BIT_DIRECTION];
         clear_pending_select <= pwdata[`BIT_CLEAR_PENDING];
         cmsk_ndtx <= pwdata[`BIT_NEW_DATA_TX];
         low_bytes_select <= pwdata[`BIT_LOW_BYTES];
         high_bytes_select <= pwdata[`BIT_HIGH_BYTES];
      end
   end

   // ****************************************
   // interface message control and data
   // ****************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         {new_data_flag, object_pending_flag, transmit_request_flag} <= 3'h0;
         {data_low_word_a, data_low_word_b, data_high_word_a, data_high_word_b} <= 64'h0;
      end
      else if (xfer_done && !cmsk_dir)
      begin
         object_pending_flag <= objs[xfer_idx].pending;
         new_data_flag <= objs[xfer_idx].new_data;
         if (low_bytes_select)
            {data_low_word_b, data_low_word_a} <= objs[xfer_idx].data[31:0];
         if (high_bytes_select)
            {data_high_word_b, data_high_word_a} <= objs[xfer_idx].data[63:32];
      end
      else if (wr_access)
      begin
         if (paddr == `OFS_MESSAGE_CONTROL)
         begin
            new_data_flag <= pwdata[`BIT_MCTL_NEW_DATA];
            object_pending_flag <= pwdata[`BIT_MCTL_PENDING];
            transmit_request_flag <= pwdata[`BIT_MCTL_TX_REQUEST];
         end
         if (paddr == `OFS_DATA_LOW_A)
            data_low_word_a <= pwdata[15:0];
         if (paddr == `OFS_DATA_LOW_B)
            data_low_word_b <= pwdata[15:0];
         if (paddr == `OFS_DATA_HIGH_A)
            data_high_word_a <= pwdata[15:0];
         if (paddr == `OFS_DATA_HIGH_B)
            data_high_word_b <= pwdata[15:0];
      end
   end

   // ****************************************
   // message object store and transmission start
   // ****************************************
   generate
      for (genvar gi = 0; gi < 32; gi++)
      begin : g_obj
         wire logic hit = xfer_done && xfer_idx == 5'(gi);
         wire logic rx_hit = rx_store && rx_index == 5'(gi);
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               objs[gi] <= '0;
            else
            begin
               // a clear and a frame arriving together: the frame wins
               if (hit && clear_pending_select)
                  objs[gi].pending <= 1'b0;
               if (hit && !cmsk_dir && cmsk_ndtx)
                  objs[gi].new_data <= 1'b0;
               if (tx_done && tx_done_index == 5'(gi))
                  objs[gi].tx_request <= 1'b0;
               if (hit && cmsk_dir && cmsk_ndtx)
                  objs[gi].tx_request <= 1'b1;
               if (hit && cmsk_dir && low_bytes_select)
                  objs[gi].data[31:0] <= {data_low_word_b, data_low_word_a};
               if (hit && cmsk_dir && high_bytes_select)
                  objs[gi].data[63:32] <= {data_high_word_b, data_high_word_a};
               if (rx_hit)
               begin
                  objs[gi].pending <= 1'b1;
                  objs[gi].new_data <= 1'b1;
                  objs[gi].data <= rx_data;
               end
            end
         end
      end
   endgenerate

   // the control register's own request bit plays no part here
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_start <= 1'b0;
         tx_index <= 5'h00;
      end
      else
      begin
         tx_start <= xfer_done && cmsk_dir && cmsk_ndtx;
         if (xfer_done)
            tx_index <= xfer_idx;
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic no_rx = !(rx_store && rx_index == xfer_idx);
   sequence s_start;
      crq_write && !busy;
   endsequence
   sequence s_hold;
      busy [*3] ##1 !busy;
   endsequence

   property p_busy_set;
      s_start |=> busy;
   endproperty
   a_busy_set: assert property (p_busy_set) else $error("busy not set by object number write");
   property p_busy_len;
      s_start |=> s_hold;
   endproperty
   a_busy_len: assert property (p_busy_len) else $error("transfer length not three cycles");
   property p_wr_clear_pend;
      xfer_done && cmsk_dir && clear_pending_select && no_rx |=> !objs[xfer_idx].pending;
   endproperty
   a_wr_clear_pend: assert property (p_wr_clear_pend) else $error("pending not cleared on write");
   property p_rd_pend;
      xfer_done && !cmsk_dir |=> object_pending_flag == $past(objs[xfer_idx].pending);
   endproperty
   a_rd_pend: assert property (p_rd_pend) else $error("pending not reported");
   property p_rd_clear_pend;
      xfer_done && !cmsk_dir && clear_pending_select && no_rx |=> !objs[xfer_idx].pending;
   endproperty
   a_rd_clear_pend: assert property (p_rd_clear_pend) else $error("pending not cleared on read");
   property p_tx;
      xfer_done && cmsk_dir && cmsk_ndtx |=> tx_start && tx_index == xfer_idx;
   endproperty
   a_tx: assert property (p_tx) else $error("transmission not started");
   property p_rd_nd;
      xfer_done && !cmsk_dir |=> new_data_flag == $past(objs[xfer_idx].new_data);
   endproperty
   a_rd_nd: assert property (p_rd_nd) else $error("new data not reported");
   property p_rd_clear_nd;
      xfer_done && !cmsk_dir && cmsk_ndtx && no_rx |=> !objs[xfer_idx].new_data;
   endproperty
   a_rd_clear_nd: assert property (p_rd_clear_nd) else $error("new data not cleared");
   property p_low;
      xfer_done && !cmsk_dir && low_bytes_select |=>
         {data_low_word_b, data_low_word_a} == $past(objs[xfer_idx].data[31:0]);
   endproperty
   a_low: assert property (p_low) else $error("low bytes not loaded");
   property p_high;
      xfer_done && cmsk_dir && high_bytes_select && no_rx |=>
         objs[xfer_idx].data[63:32] == $past({data_high_word_b, data_high_word_a});
   endproperty
   a_high: assert property (p_high) else $error("high bytes not stored");
endmodule

/* verif/can_msg_engine.sv */
/*
 * behavioural protocol engine beside the message store: stores frames when
 * the bench asks and acknowledges each transmission after a short or long wait.
 * assumes store() is called just after a rising edge of pclk.
 */
module can_msg_engine
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // frame store
   output      logic        rx_store,
   output      logic [4:0]  rx_index,
   output      logic [63:0] rx_data,
   // transmission handshake
   input  wire logic        tx_start,
   input  wire logic [4:0]  tx_index,
   output      logic        tx_done,
   output      logic [4:0]  tx_done_index
);
   timeunit 1ns;
   timeprecision 1ps;

   logic slow;

   initial
   begin
      rx_store      = 1'b0;
      rx_index      = 5'h00;
      rx_data       = 64'h0;
      tx_done       = 1'b0;
      tx_done_index = 5'h00;
      slow          = 1'b0;
   end

   // one-cycle store pulse; lines show the inverse once released and rest
   // for a cycle, so that a following store never re-raises them in one step
   task automatic store(input logic [4:0] idx, input logic [63:0] d);
      rx_index <= idx;
      rx_data  <= d;
      rx_store <= 1'b1;
      @(posedge pclk);
      rx_store <= 1'b0;
      rx_index <= ~idx;
      rx_data  <= ~d;
      @(posedge pclk);
   endtask

   // acknowledge alternately promptly and slowly
   always
   begin
      @(posedge pclk iff (presetn && tx_start));
      tx_done_index <= tx_index;
      repeat (slow ? 6 : 1) @(posedge pclk);
      tx_done <= 1'b1;
      @(posedge pclk);
      tx_done       <= 1'b0;
      tx_done_index <= ~tx_done_index;
      slow = ~slow;
   end
endmodule

/* verif/can_if_transfer_select_tb_top.sv */
/*
 * self-checking bench of the transfer-select block: apb master with noted
 * expectations, read and transmission watchers, engine model on the far side.
 * assumes can_xfer_defines.svh on the include path.
 */
`include "can_xfer_defines.svh"
module can_if_transfer_select_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        rx_store, tx_start, tx_done;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [4:0]  rx_index, tx_index, tx_done_index;
   logic [63:0] rx_data, obj_a, obj_b, wd;
   logic [33:0] rd_q[$];
   logic [33:0] note;
   logic [4:0]  tx_q[$];
   int          error_cnt, n_checks;

   can_if_transfer_select dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_store(rx_store), .rx_index(rx_index), .rx_data(rx_data),
      .tx_start(tx_start), .tx_index(tx_index), .tx_done(tx_done), .tx_done_index(tx_done_index));

   can_msg_engine eng (.pclk(pclk), .presetn(presetn), .rx_store(rx_store), .rx_index(rx_index),
      .rx_data(rx_data), .tx_start(tx_start), .tx_index(tx_index), .tx_done(tx_done),
      .tx_done_index(tx_done_index));

   initial pclk = 1'b0;
   always #5 pclk = ~pclk;

   // ****************************************
   // checking
   // ****************************************
   task automatic cmp_rd(input logic [32:0] got, input logic [32:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR %0t read got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_tx(input logic [4:0] got, input logic [4:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR %0t transmission index %h expected %h", $time, got, exp);
      end
   endtask

   always @(posedge pclk)
      if (psel === 1'b1 && penable === 1'b1 && pwrite === 1'b0 && pready === 1'b1)
      begin
         note = rd_q.pop_front();
         if (note[33] === 1'b0)
            cmp_rd({pslverr, prdata}, note[32:0]);
      end

   always @(posedge pclk)
      if (presetn === 1'b1 && tx_start !== 1'b0)
         cmp_tx(tx_index, (tx_q.size() > 0) ? tx_q.pop_front() : 5'hxx);

   task automatic stop_test;
      if (tx_q.size() != 0)
      begin
         error_cnt++;
         $display("ERROR %0t transmission missing", $time);
      end
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ****************************************
   // apb master and transfer helpers
   // ****************************************
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1)
      begin
         error_cnt++;
         $display("ERROR %0t access never ended", $time);
         stop_test();
      end
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err = 1'b0);
      rd_q.push_back({1'b0, err, e});
      apb(1'b0, a, 32'h0);
   endtask

   task automatic xfer(input logic [7:0] m, input logic [5:0] num);
      apb(1'b1, `OFS_COMMAND_MASK, {24'h0, m});
      rd(`OFS_COMMAND_MASK, {24'h0, m});
      apb(1'b1, `OFS_COMMAND_REQUEST, {26'h0, num});
      rd(`OFS_COMMAND_REQUEST, {16'h0, 1'b1, 9'h0, num});
      rd(`OFS_COMMAND_REQUEST, {26'h0, num});
   endtask

   task automatic wr_obj(input logic [63:0] d);
      apb(1'b1, `OFS_DATA_LOW_A, {16'h0, d[15:0]});
      apb(1'b1, `OFS_DATA_LOW_B, {16'h0, d[31:16]});
      apb(1'b1, `OFS_DATA_HIGH_A, {16'h0, d[47:32]});
      apb(1'b1, `OFS_DATA_HIGH_B, {16'h0, d[63:48]});
   endtask

   task automatic rd_obj(input logic [63:0] e);
      rd(`OFS_DATA_LOW_A, {16'h0, e[15:0]});
      rd(`OFS_DATA_LOW_B, {16'h0, e[31:16]});
      rd(`OFS_DATA_HIGH_A, {16'h0, e[47:32]});
      rd(`OFS_DATA_HIGH_B, {16'h0, e[63:48]});
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   initial
   begin
      presetn = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0;
      void'($urandom(15375));
      obj_a = {$urandom, $urandom};
      obj_b = {$urandom, $urandom};
      wd    = {$urandom, $urandom};
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(`OFS_COMMAND_REQUEST, 32'h1);
      rd(`OFS_COMMAND_MASK, 32'h0);
      rd(`OFS_MESSAGE_CONTROL, 32'h0);
      rd(8'h00, 32'h0, 1'b1);
      $display("test reset and map done");
      eng.store(5'h1f, obj_a);
      eng.store(5'h04, obj_b);
      xfer(8'h03, 6'h00);
      rd(`OFS_MESSAGE_CONTROL, 32'ha000);
      rd_obj(obj_a);
      xfer(8'h0c, 6'h00);
      rd(`OFS_MESSAGE_CONTROL, 32'ha000);
      rd_obj(obj_a);
      xfer(8'h00, 6'h20);
      rd(`OFS_MESSAGE_CONTROL, 32'h0);
      xfer(8'h03, 6'h25);
      rd(`OFS_MESSAGE_CONTROL, 32'ha000);
      rd_obj(obj_b);
      $display("test read selects done");
      eng.store(5'h09, obj_a);
      wr_obj(wd);
      tx_q.push_back(5'h09);
      xfer(8'h8e, 6'h0a);
      xfer(8'h03, 6'h0a);
      rd(`OFS_MESSAGE_CONTROL, 32'h8000);
      rd_obj({obj_a[63:32], wd[31:0]});
      eng.store(5'h0b, obj_b);
      wr_obj(wd);
      apb(1'b1, `OFS_MESSAGE_CONTROL, 32'h0100);
      rd(`OFS_MESSAGE_CONTROL, 32'h0100);
      xfer(8'h81, 6'h0c);
      apb(1'b1, `OFS_MESSAGE_CONTROL, 32'h0);
      xfer(8'h03, 6'h0c);
      rd(`OFS_MESSAGE_CONTROL, 32'ha000);
      rd_obj({wd[63:32], obj_b[31:0]});
      repeat (10) @(posedge pclk);
      $display("test write selects done");
      stop_test();
   end
endmodule
